// *** src/pcl_loader.sv ***
/*
 * Power-on program loader: chooses cartridge or internal program, runs the
 * automatic download or one-shot upload, and halts on transfer or program error.
 * Assumes cartridge status pins are asynchronous and may change at any time while powered,
 * internal protection settings and memories are on clk.
 */
`timescale 1ns/1ns
module pcl_loader #(
    parameter int AW    = 12,
    parameter int DW    = 16,
    parameter int PW    = 16,
    parameter int WORDS = 4096
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          cart_present,
    input  wire logic          cart_has_prog,
    input  wire logic          cart_dl_en,
    input  wire logic          cart_ul_set,
    input  wire logic          cart_unsupported,
    input  wire logic [PW-1:0] cart_password,
    input  wire logic          int_ul_prohibit,
    input  wire logic          int_pw_protect,
    input  wire logic [PW-1:0] int_password,
    input  wire logic          cfg_ul_req,
    input  wire logic          int_erase_ack,
    input  wire logic          cart_erase_ack,
    input  wire logic [DW-1:0] int_rd_data,
    input  wire logic [DW-1:0] cart_rd_data,
    output logic               int_erase_r,
    output logic               cart_erase_r,
    output logic               int_rd_r,
    output logic               cart_rd_r,
    output logic               int_wr_r,
    output logic               cart_wr_r,
    output logic [AW-1:0]      rd_addr_r,
    output logic [AW-1:0]      wr_addr_r,
    output logic [DW-1:0]      wr_data_r,
    output logic               run_r,
    output logic               run_from_cart_r,
    output logic               xfer_err_r,
    output logic               prog_err_r,
    output logic               cart_ul_clr_r,
    output logic               cart_ul_arm_r
);
    localparam int SB = pcl_pkg::SYNC_BITS + PW;

    function automatic logic pw_match(input logic prot, input logic [PW-1:0] a,
                                      input logic [PW-1:0] b);
        pw_match = !prot || (a == b);
    endfunction

    pcl_pkg::pcl_state_e st_r;
    logic [SB-1:0]       sync1_r;
    logic [SB-1:0]       sync2_r;
    logic [3:0]          cnt_r;
    logic                snap_present_r;
    logic                snap_prog_r;
    logic                snap_dl_r;
    logic                snap_ul_r;
    logic                snap_unsup_r;
    logic [PW-1:0]       snap_pw_r;
    logic                xf_start_r;
    logic                xf_dir_r;
    logic                xf_only_r;
    logic                xf_busy;
    logic                xf_done;

    wire [SB-1:0] pins_raw = {cart_present, cart_has_prog, cart_dl_en, cart_ul_set,
                              cart_unsupported, cart_password};
    wire          settled  = (cnt_r == pcl_pkg::SETTLE_CYCLES);
    wire          pw_ok    = pw_match(int_pw_protect, snap_pw_r, int_password);
    wire          cart_prog = snap_present_r && snap_prog_r && !snap_ul_r;
    wire          ul_req   = snap_present_r && snap_ul_r;
    wire          dl_req   = cart_prog && snap_dl_r;
    wire          ul_bad   = ul_req && (int_ul_prohibit || !pw_ok);
    wire          dl_bad   = dl_req && !pw_ok;
    wire          ul_go    = ul_req && !ul_bad;
    wire          dl_go    = dl_req && !dl_bad && !snap_unsup_r;
    wire          unsup    = cart_prog && snap_unsup_r && !dl_bad;

    // Pins may change at any time, so only sync2_r is read by logic
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r            <= pcl_pkg::ST_SETTLE;
            cnt_r           <= '0;
            snap_present_r  <= 1'b0;
            snap_prog_r     <= 1'b0;
            snap_dl_r       <= 1'b0;
            snap_ul_r       <= 1'b0;
            snap_unsup_r    <= 1'b0;
            snap_pw_r       <= '0;
            xf_start_r      <= 1'b0;
            xf_dir_r        <= 1'b0;
            xf_only_r       <= 1'b0;
            run_r           <= 1'b0;
            run_from_cart_r <= 1'b0;
            xfer_err_r      <= 1'b0;
            prog_err_r      <= 1'b0;
            cart_ul_clr_r   <= 1'b0;
            cart_ul_arm_r   <= 1'b0;
        end else begin
            xf_start_r    <= 1'b0;
            cart_ul_clr_r <= 1'b0;
            cart_ul_arm_r <= 1'b0;
            case (st_r)
                pcl_pkg::ST_SETTLE: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (settled) begin
                        // Captured once; insertion or removal later has no effect
                        {snap_present_r, snap_prog_r, snap_dl_r, snap_ul_r,
                         snap_unsup_r, snap_pw_r} <= sync2_r;
                        st_r <= pcl_pkg::ST_DECIDE;
                    end
                end
                pcl_pkg::ST_DECIDE: begin
                    if (ul_bad || dl_bad) begin
                        xfer_err_r <= 1'b1;
                        st_r       <= pcl_pkg::ST_HALT;
                    end else if (ul_go) begin
                        xf_start_r <= 1'b1;
                        xf_dir_r   <= pcl_pkg::DIR_UL;
                        xf_only_r  <= 1'b0;
                        st_r       <= pcl_pkg::ST_XFER;
                    end else if (unsup) begin
                        // Checked before any download so the internal copy survives
                        prog_err_r <= 1'b1;
                        st_r       <= pcl_pkg::ST_HALT;
                    end else if (dl_go) begin
                        xf_start_r <= 1'b1;
                        xf_dir_r   <= pcl_pkg::DIR_DL;
                        xf_only_r  <= 1'b0;
                        st_r       <= pcl_pkg::ST_XFER;
                    end else begin
                        run_r           <= 1'b1;
                        run_from_cart_r <= cart_prog;
                        st_r            <= pcl_pkg::ST_RUN;
                    end
                end
                pcl_pkg::ST_XFER: if (xf_done) begin
                    cart_ul_clr_r   <= (xf_dir_r == pcl_pkg::DIR_UL);
                    run_r           <= 1'b1;
                    run_from_cart_r <= (xf_dir_r == pcl_pkg::DIR_DL);
                    st_r            <= pcl_pkg::ST_RUN;
                end
                pcl_pkg::ST_RUN: if (cfg_ul_req) begin
                    xf_start_r <= 1'b1;
                    xf_dir_r   <= pcl_pkg::DIR_UL;
                    xf_only_r  <= 1'b1;
                    st_r       <= pcl_pkg::ST_CFG;
                end
                pcl_pkg::ST_CFG: if (xf_done) begin
                    cart_ul_arm_r <= 1'b1;
                    st_r          <= pcl_pkg::ST_RUN;
                end
                pcl_pkg::ST_HALT: run_r <= 1'b0;
                default: st_r <= pcl_pkg::ST_HALT;
            endcase
        end
    end

    pcl_xfer #(
        .AW    (AW),
        .DW    (DW),
        .WORDS (WORDS)
    ) u_xfer (
        .clk            (clk),
        .nrst           (nrst),
        .start          (xf_start_r),
        .dir            (xf_dir_r),
        .erase_only     (xf_only_r),
        .int_erase_ack  (int_erase_ack),
        .cart_erase_ack (cart_erase_ack),
        .int_rd_data    (int_rd_data),
        .cart_rd_data   (cart_rd_data),
        .int_erase_r    (int_erase_r),
        .cart_erase_r   (cart_erase_r),
        .int_rd_r       (int_rd_r),
        .cart_rd_r      (cart_rd_r),
        .int_wr_r       (int_wr_r),
        .cart_wr_r      (cart_wr_r),
        .rd_addr_r      (rd_addr_r),
        .wr_addr_r      (wr_addr_r),
        .wr_data_r      (wr_data_r),
        .busy_r         (xf_busy),
        .done_r         (xf_done)
    );

    // Helper: internal store erased since the current transfer began
    logic int_erased_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            int_erased_r <= 1'b0;
        end else if (xf_start_r) begin
            int_erased_r <= 1'b0;
        end else if (int_erase_r && int_erase_ack) begin
            int_erased_r <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_CART_PREF: assert property (
        (st_r == pcl_pkg::ST_DECIDE && cart_prog && !snap_unsup_r && !dl_req)
        |=> run_r && run_from_cart_r)
        else $error("cartridge program not preferred");
    AST_ROM_FALLBACK: assert property (
        (run_r && !(snap_present_r && snap_prog_r)) |-> !run_from_cart_r)
        else $error("internal program not selected");
    AST_ERASE_FIRST: assert property (
        int_wr_r |-> int_erased_r)
        else $error("internal write before erase");
    AST_AUTO_DL: assert property (
        (st_r == pcl_pkg::ST_DECIDE && dl_go && !ul_req)
        |=> xf_start_r && xf_dir_r == pcl_pkg::DIR_DL ##1 int_erase_r)
        else $error("automatic download not started");
    AST_AUTO_UL: assert property (
        (st_r == pcl_pkg::ST_DECIDE && ul_go)
        |=> xf_start_r && xf_dir_r == pcl_pkg::DIR_UL ##1 cart_erase_r)
        else $error("automatic upload not started");
    AST_UL_CONSUME: assert property (
        (st_r == pcl_pkg::ST_XFER && xf_done && xf_dir_r == pcl_pkg::DIR_UL)
        |=> cart_ul_clr_r ##1 !cart_ul_clr_r)
        else $error("upload setting not consumed once");
    AST_CFG_ERASE: assert property (
        (st_r == pcl_pkg::ST_RUN && cfg_ul_req) |=> xf_start_r && xf_only_r ##1 cart_erase_r)
        else $error("configuration did not erase cartridge");
    AST_PROHIB_ERR: assert property (
        (st_r == pcl_pkg::ST_DECIDE && ul_req && int_ul_prohibit)
        |=> xfer_err_r && !xf_start_r)
        else $error("prohibited upload not refused");
    AST_PW_ERR: assert property (
        (st_r == pcl_pkg::ST_DECIDE && snap_present_r && (snap_ul_r || dl_req)
         && int_pw_protect && snap_pw_r != int_password) |=> xfer_err_r ##1 !run_r)
        else $error("password mismatch not flagged");
    AST_HALT: assert property (
        xfer_err_r |-> !run_r && !cart_wr_r && !xf_busy)
        else $error("operation continues after transfer error");
    AST_PW_GATE: assert property (
        $rose(xf_busy) && !xf_only_r |-> pw_match(int_pw_protect, snap_pw_r, int_password))
        else $error("transfer with mismatching password");
    AST_UNSUP: assert property (
        (st_r == pcl_pkg::ST_DECIDE && unsup && !ul_req) |=> prog_err_r && !run_r)
        else $error("unsupported program not flagged");
    AST_SNAP_HOLD: assert property (
        (st_r != pcl_pkg::ST_SETTLE) |=> $stable(snap_pw_r) && $stable(snap_present_r))
        else $error("cartridge state resampled");
    AST_RUN_AFTER: assert property (
        $rose(run_r) |-> !xf_busy && !xfer_err_r && !prog_err_r)
        else $error("run began during transfer");

    COV_DL_RUN: cover property (
        (st_r == pcl_pkg::ST_XFER && xf_done && xf_dir_r == pcl_pkg::DIR_DL) ##1 $rose(run_r));
    COV_UL_RUN: cover property (cart_ul_clr_r ##1 run_r);
    COV_XFER_ERR: cover property ($rose(xfer_err_r));
    COV_CFG: cover property ($rose(cart_ul_arm_r));
endmodule

// *** src/pcl_pkg.sv ***
/*
 * Shared constants and state types of the program cartridge loader.
 * Assumes nothing beyond a SystemVerilog compiler; every user writes pcl_pkg::name.
 */
package pcl_pkg;
    // Cycles the synchronised cartridge pins must settle before they are captured
    localparam logic [3:0] SETTLE_CYCLES = 4'h4;
    localparam logic       DIR_DL        = 1'b0;
    localparam logic       DIR_UL        = 1'b1;
    localparam int         SYNC_BITS     = 5;

    typedef enum logic [5:0] {
        ST_SETTLE = 6'h01,
        ST_DECIDE = 6'h02,
        ST_XFER   = 6'h04,
        ST_RUN    = 6'h08,
        ST_CFG    = 6'h10,
        ST_HALT   = 6'h20
    } pcl_state_e;

    typedef enum logic [4:0] {
        X_IDLE  = 5'h01,
        X_ERASE = 5'h02,
        X_READ  = 5'h04,
        X_WRITE = 5'h08,
        X_DONE  = 5'h10
    } pcl_xst_e;
endpackage

// *** src/pcl_xfer.sv ***
/*
 * Word copy engine: erases the destination store, then, unless erase_only is set, copies WORDS words.
 * Assumes both stores sit on clk, answer a read one cycle after rd, and
 * hold erase_ack high for at least one cycle once an erase has finished.
 */
`timescale 1ns/1ns
module pcl_xfer #(
    parameter int AW    = 12,
    parameter int DW    = 16,
    parameter int WORDS = 4096
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          start,
    input  wire logic          dir,
    input  wire logic          erase_only,
    input  wire logic          int_erase_ack,
    input  wire logic          cart_erase_ack,
    input  wire logic [DW-1:0] int_rd_data,
    input  wire logic [DW-1:0] cart_rd_data,
    output logic               int_erase_r,
    output logic               cart_erase_r,
    output logic               int_rd_r,
    output logic               cart_rd_r,
    output logic               int_wr_r,
    output logic               cart_wr_r,
    output logic [AW-1:0]      rd_addr_r,
    output logic [AW-1:0]      wr_addr_r,
    output logic [DW-1:0]      wr_data_r,
    output logic               busy_r,
    output logic               done_r
);
    localparam logic [AW-1:0] LAST_ADDR = AW'(WORDS - 1);

    pcl_pkg::pcl_xst_e st_r;
    logic              dir_r;
    logic              only_r;

    wire               is_ul    = (dir_r == pcl_pkg::DIR_UL);
    wire               er_ack   = is_ul ? cart_erase_ack : int_erase_ack;
    wire  [DW-1:0]     src_data = is_ul ? int_rd_data : cart_rd_data;
    wire               last     = (rd_addr_r == LAST_ADDR);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r         <= pcl_pkg::X_IDLE;
            dir_r        <= 1'b0;
            only_r       <= 1'b0;
            int_erase_r  <= 1'b0;
            cart_erase_r <= 1'b0;
            int_rd_r     <= 1'b0;
            cart_rd_r    <= 1'b0;
            int_wr_r     <= 1'b0;
            cart_wr_r    <= 1'b0;
            rd_addr_r    <= '0;
            wr_addr_r    <= '0;
            wr_data_r    <= '0;
            busy_r       <= 1'b0;
            done_r       <= 1'b0;
        end else begin
            done_r    <= 1'b0;
            int_rd_r  <= 1'b0;
            cart_rd_r <= 1'b0;
            int_wr_r  <= 1'b0;
            cart_wr_r <= 1'b0;
            case (st_r)
                pcl_pkg::X_IDLE: if (start) begin
                    dir_r        <= dir;
                    only_r       <= erase_only;
                    int_erase_r  <= (dir == pcl_pkg::DIR_DL);
                    cart_erase_r <= (dir == pcl_pkg::DIR_UL);
                    busy_r       <= 1'b1;
                    st_r         <= pcl_pkg::X_ERASE;
                end
                pcl_pkg::X_ERASE: if (er_ack) begin
                    int_erase_r  <= 1'b0;
                    cart_erase_r <= 1'b0;
                    if (only_r) begin
                        done_r <= 1'b1;
                        busy_r <= 1'b0;
                        st_r   <= pcl_pkg::X_IDLE;
                    end else begin
                        rd_addr_r <= '0;
                        int_rd_r  <= is_ul;
                        cart_rd_r <= !is_ul;
                        st_r      <= pcl_pkg::X_READ;
                    end
                end
                pcl_pkg::X_READ: st_r <= pcl_pkg::X_WRITE;
                pcl_pkg::X_WRITE: begin
                    wr_data_r <= src_data;
                    wr_addr_r <= rd_addr_r;
                    int_wr_r  <= !is_ul;
                    cart_wr_r <= is_ul;
                    if (last) begin
                        st_r <= pcl_pkg::X_DONE;
                    end else begin
                        // Next read overlaps this write to keep two cycles per word
                        rd_addr_r <= rd_addr_r + 1'b1;
                        int_rd_r  <= is_ul;
                        cart_rd_r <= !is_ul;
                        st_r      <= pcl_pkg::X_READ;
                    end
                end
                pcl_pkg::X_DONE: begin
                    done_r <= 1'b1;
                    busy_r <= 1'b0;
                    st_r   <= pcl_pkg::X_IDLE;
                end
                default: st_r <= pcl_pkg::X_IDLE;
            endcase
        end
    end
endmodule

// *** test/pcl_store_model.sv ***
/*
 * Behavioural program store used for both the cartridge and the internal store.
 * Assumes the loader drives strobes on clk; reads answer one cycle later and
 * an erase is acknowledged DLY cycles after the request is first seen.
 */
`timescale 1ns/1ns
module pcl_store_model #(
    parameter int          N      = 4,
    parameter int          DLY    = 0,
    parameter logic [15:0] ERASED = 16'hffff
) (
    input  wire logic        clk,
    input  wire logic        erase,
    input  wire logic        rd,
    input  wire logic        wr,
    input  wire logic [11:0] rd_addr,
    input  wire logic [11:0] wr_addr,
    input  wire logic [15:0] wr_data,
    output logic             erase_ack,
    output logic [15:0]      rd_data
);
    logic [15:0] mem [0:N-1];
    int          cnt = 0;

    // Outputs have one driver only; erase_ack settles low on the first edge,
    // long before the loader can raise an erase request
    task automatic load(input logic [15:0] base);
        for (int i = 0; i < N; i++) begin
            mem[i] = base + 16'(i);
        end
    endtask

    always @(posedge clk) begin
        if (erase && !erase_ack) begin
            cnt <= cnt + 1;
            if (cnt == DLY) begin
                erase_ack <= 1'b1;
                for (int i = 0; i < N; i++) begin
                    mem[i] <= ERASED;
                end
            end
        end else begin
            erase_ack <= 1'b0;
            cnt       <= 0;
        end
        // Outside a read answer the bus toggles so stale data cannot pass as valid
        rd_data <= rd ? mem[rd_addr] : ~rd_data;
        if (wr) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule

// *** test/pcl_tb.sv ***
/*
 * Self-checking bench of the program cartridge loader with two store models.
 * Assumes pcl_loader and pcl_store_model are compiled first; WORDS is cut to 4.
 */
`timescale 1ns/1ns
module testbench;
    localparam int W = 4;
    logic        clk, nrst, cart_present, cart_has_prog, cart_dl_en, cart_ul_set;
    logic        cart_unsupported, int_ul_prohibit, int_pw_protect, cfg_ul_req;
    logic [15:0] cart_password, int_password, int_rd_data, cart_rd_data;
    logic        int_erase_ack, cart_erase_ack, int_erase_r, cart_erase_r;
    logic        int_rd_r, cart_rd_r, int_wr_r, cart_wr_r, run_r, run_from_cart_r;
    logic        xfer_err_r, prog_err_r, cart_ul_clr_r, cart_ul_arm_r;
    logic [11:0] rd_addr_r, wr_addr_r;
    logic [15:0] wr_data_r;
    int          n_errors = 0, checks = 0, cyc = 0, n_clr = 0, n_arm = 0, n_wr_run = 0;

    pcl_loader #(.WORDS(W)) dut_u (.clk(clk), .nrst(nrst), .cart_present(cart_present),
        .cart_has_prog(cart_has_prog), .cart_dl_en(cart_dl_en), .cart_ul_set(cart_ul_set),
        .cart_unsupported(cart_unsupported), .cart_password(cart_password),
        .int_ul_prohibit(int_ul_prohibit), .int_pw_protect(int_pw_protect),
        .int_password(int_password), .cfg_ul_req(cfg_ul_req), .int_erase_ack(int_erase_ack),
        .cart_erase_ack(cart_erase_ack), .int_rd_data(int_rd_data),
        .cart_rd_data(cart_rd_data), .int_erase_r(int_erase_r), .cart_erase_r(cart_erase_r),
        .int_rd_r(int_rd_r), .cart_rd_r(cart_rd_r), .int_wr_r(int_wr_r),
        .cart_wr_r(cart_wr_r), .rd_addr_r(rd_addr_r), .wr_addr_r(wr_addr_r),
        .wr_data_r(wr_data_r), .run_r(run_r), .run_from_cart_r(run_from_cart_r),
        .xfer_err_r(xfer_err_r), .prog_err_r(prog_err_r), .cart_ul_clr_r(cart_ul_clr_r),
        .cart_ul_arm_r(cart_ul_arm_r));
    // Slow internal store, prompt cartridge
    pcl_store_model #(.N(W), .DLY(3)) int_u (.clk(clk), .erase(int_erase_r), .rd(int_rd_r),
        .wr(int_wr_r), .rd_addr(rd_addr_r), .wr_addr(wr_addr_r), .wr_data(wr_data_r),
        .erase_ack(int_erase_ack), .rd_data(int_rd_data));
    pcl_store_model #(.N(W), .DLY(0)) cart_u (.clk(clk), .erase(cart_erase_r),
        .rd(cart_rd_r), .wr(cart_wr_r), .rd_addr(rd_addr_r), .wr_addr(wr_addr_r),
        .wr_data(wr_data_r), .erase_ack(cart_erase_ack), .rd_data(cart_rd_data));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc = cyc + 1;
        n_clr = n_clr + int'(cart_ul_clr_r);
        n_arm = n_arm + int'(cart_ul_arm_r);
        n_wr_run = n_wr_run + int'(run_r & (int_wr_r | cart_wr_r));
        if (cyc == 5000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic check_flags(input logic [3:0] exp);
        check({28'h0, run_r, run_from_cart_r, xfer_err_r, prog_err_r}, {28'h0, exp});
    endtask

    task automatic check_store(input logic sel, input logic [15:0] base, input logic inc);
        for (int i = 0; i < W; i++) begin
            check({16'h0, sel ? cart_u.mem[i] : int_u.mem[i]}, {16'h0, base + 16'(inc * i)});
        end
    endtask

    // Pins: present, has_prog, dl_en, ul_set, unsupported, prohibit, pw_protect
    task automatic power_on(input logic [6:0] pins, input logic [15:0] cpw);
        nrst = 1'b0;
        {cart_present, cart_has_prog, cart_dl_en, cart_ul_set, cart_unsupported,
            int_ul_prohibit, int_pw_protect} = pins;
        cart_password = cpw;
        int_u.load(16'h1000);
        cart_u.load(16'ha000);
        repeat (5) @(negedge clk);
        n_clr = 0;
        n_arm = 0;
        n_wr_run = 0;
        nrst = 1'b1;
        for (int i = 0; i < 60 && !(run_r | xfer_err_r | prog_err_r); i++) @(negedge clk);
        repeat (3) @(negedge clk);
    endtask

    task automatic t_select();
        power_on(7'b0000000, 16'h0000);
        check_flags(4'b1000);
        power_on(7'b1000000, 16'h0000);
        check_flags(4'b1000);
        power_on(7'b1100000, 16'h0000);
        check_flags(4'b1100);
        cart_present = 1'b0;
        cart_has_prog = 1'b0;
        repeat (10) @(negedge clk);
        check_flags(4'b1100);
    endtask

    task automatic t_download();
        power_on(7'b1110001, 16'h5a5a);
        check_flags(4'b1100);
        check_store(1'b0, 16'ha000, 1'b1);
        check(n_wr_run, 0);
        power_on(7'b1110001, 16'h0001);
        check_flags(4'b0010);
        check_store(1'b0, 16'h1000, 1'b1);
    endtask

    task automatic t_upload();
        power_on(7'b1001001, 16'h5a5a);
        check_store(1'b1, 16'h1000, 1'b1);
        check(n_clr, 1);
        check({31'h0, run_r}, 1);
        power_on(7'b1001010, 16'h0000);
        check_flags(4'b0010);
        check_store(1'b1, 16'ha000, 1'b1);
        check(n_clr, 0);
        power_on(7'b1001001, 16'h1234);
        check_flags(4'b0010);
        check_store(1'b1, 16'ha000, 1'b1);
    endtask

    task automatic t_unsupported();
        power_on(7'b1110100, 16'h0000);
        check({31'h0, prog_err_r}, 1);
        check_store(1'b0, 16'h1000, 1'b1);
    endtask

    task automatic t_cfg_upload();
        power_on(7'b1000000, 16'h0000);
        cfg_ul_req = 1'b1;
        @(negedge clk);
        cfg_ul_req = 1'b0;
        for (int i = 0; i < 30 && n_arm == 0; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        check(n_arm, 1);
        check_store(1'b1, 16'hffff, 1'b0);
        check({31'h0, run_r}, 1);
    endtask

    initial begin
        nrst = 1'b0;
        {cart_present, cart_has_prog, cart_dl_en, cart_ul_set, cart_unsupported} = 5'h00;
        int_ul_prohibit = 1'b0;
        int_pw_protect = 1'b0;
        cfg_ul_req = 1'b0;
        cart_password = 16'h0000;
        int_password = 16'h5a5a;
        @(negedge clk);
        t_select();
        t_download();
        t_upload();
        t_unsupported();
        t_cfg_upload();
        complete_run();
    end
endmodule
